// ==== rtl/ebrh_regs.vh ====
// constants of the external bus ready/hold controller
// assumes inclusion by bare name from the controller module and the bench top
`ifndef EBRH_REGS_VH
`define EBRH_REGS_VH

// register offsets on the plain register port
`define EBRH_ADDR_W        8
`define EBRH_OFS_CTRL      8'h00
`define EBRH_OFS_STATUS    8'h04

// control register fields
`define EBRH_CTRL_MUX      0
`define EBRH_CTRL_RWDLY    1
`define EBRH_CTRL_RDYEN    2
`define EBRH_CTRL_TRIW     3
`define EBRH_CTRL_MCW_LO   4
`define EBRH_CTRL_MCW_HI   7
`define EBRH_CTRL_W        8
`define EBRH_CTRL_RST      8'h00

// memory-cycle wait count width
`define EBRH_MCW_W         4
`define EBRH_MCW_ZERO      4'h0
`define EBRH_MCW_ONE       4'h1

// state codes
`define EBRH_ST_W          4
`define EBRH_ST_IDLE       4'h0
`define EBRH_ST_ALE        4'h1
`define EBRH_ST_DLY        4'h2
`define EBRH_ST_CMD        4'h3
`define EBRH_ST_END        4'h4
`define EBRH_ST_MUXW       4'h5
`define EBRH_ST_TRIW       4'h6
`define EBRH_ST_GRANT      4'h7
`define EBRH_ST_REGAIN     4'h8

// bus widths
`define EBRH_A_W           18
`define EBRH_D_W           16

`endif

// ==== rtl/ebrh_ctrl.v ====
// external bus controller: ready wait states, mux/tristate gaps, hold arbitration
// assumes clk at 50 MHz; pins ready_n, hold_request_n, bus_data_in are asynchronous
`timescale 1ns/10ps
`default_nettype none
`include "ebrh_regs.vh"

// Notes on behaviour
// - ready sampled high adds one more wait state and samples again
// - ready sampled low ends the running bus cycle
// - cycle holds programmed memory waits before ready counts; rw delay shifts command
// - multiplexed modes append a mux wait, optionally a tristate wait
// - gap is three output clocks muxed with tristate wait, one demuxed without
// - hold request is granted only after the running bus cycle ends
// - regain request asserted only after the bus is released and granted
// - regain sequence starts only when the hold request is removed
// - grant and regain outputs change only on output clock edges
// - after regaining, the next self-driven cycle may start
module ebrh_ctrl (
  // clock and reset
  input  wire                       clk,
  input  wire                       srst,
  // register port
  input  wire [`EBRH_ADDR_W-1:0]    reg_addr,
  input  wire [31:0]                reg_wdata,
  input  wire                       reg_wr,
  input  wire                       reg_rd,
  output reg  [31:0]                reg_rdata,
  // user request side
  input  wire                       req_valid,
  input  wire                       req_write,
  input  wire [1:0]                 req_byte_en,
  input  wire [`EBRH_A_W-1:0]       req_addr,
  input  wire [`EBRH_D_W-1:0]       req_wdata,
  output reg                        req_busy,
  output reg                        resp_done,
  output reg  [`EBRH_D_W-1:0]       resp_rdata,
  // bus pins
  output reg                        system_clock_output,
  output reg                        ale,
  output reg                        rd_n,
  output reg                        wr_n,
  output reg                        high_byte_select_n,
  output reg  [`EBRH_A_W-1:0]       bus_addr,
  output reg  [`EBRH_D_W-1:0]       bus_data_out,
  input  wire [`EBRH_D_W-1:0]       bus_data_in,
  output reg                        addr_oe_n,
  output reg                        data_oe_n,
  output reg                        ctrl_oe_n,
  input  wire                       ready_n,
  // arbitration pins
  input  wire                       hold_request_n,
  output reg                        bus_grant_ack_n,
  output reg                        bus_regain_request_n
);

  reg  [`EBRH_CTRL_W-1:0] ctrl_reg;
  reg  [`EBRH_ST_W-1:0]   state_reg;
  reg  [`EBRH_MCW_W-1:0]  wait_cnt_reg;
  // one pending slot; a second request waits behind req_busy
  reg                     pend_reg;
  reg                     pend_write_reg;
  reg  [1:0]              pend_be_reg;
  reg  [`EBRH_A_W-1:0]    pend_addr_reg;
  reg  [`EBRH_D_W-1:0]    pend_wdata_reg;
  reg                     ready_meta_reg;
  reg                     ready_sync_reg;
  reg                     hold_meta_reg;
  reg                     hold_sync_reg;
  reg  [`EBRH_D_W-1:0]    din_meta_reg;
  reg  [`EBRH_D_W-1:0]    din_sync_reg;

  wire                    mux_mode = ctrl_reg[`EBRH_CTRL_MUX];
  wire                    rw_delay = ctrl_reg[`EBRH_CTRL_RWDLY];
  wire                    ready_en = ctrl_reg[`EBRH_CTRL_RDYEN];
  wire                    tri_wait = ctrl_reg[`EBRH_CTRL_TRIW];
  wire [`EBRH_MCW_W-1:0]  mcw      = ctrl_reg[`EBRH_CTRL_MCW_HI:`EBRH_CTRL_MCW_LO];
  // state moves on the edge that raises the output clock
  wire                    ce       = ~system_clock_output;
  wire                    hold_req = ~hold_sync_reg;
  // ready disabled: the cycle ends once the memory waits are spent
  wire                    cmd_done = (wait_cnt_reg == `EBRH_MCW_ZERO) &&
                                     (~ready_en || ~ready_sync_reg);

  // output clock divider: one output period is two clk periods
  // one divider only; every state move waits for the enable on its rising edge
  always @(posedge clk) begin
    if (srst) begin
      system_clock_output <= 1'b0;
    end else begin
      system_clock_output <= ~system_clock_output;
    end
  end

  // two-flop synchronisers for asynchronous pins
  // two clk of latency on every pin: a ready low shorter than that may be missed,
  // and a read whose command lasts one output clock returns the word from before it
  always @(posedge clk) begin
    if (srst) begin
      ready_meta_reg <= 1'b1;
      ready_sync_reg <= 1'b1;
      hold_meta_reg  <= 1'b1;
      hold_sync_reg  <= 1'b1;
      din_meta_reg   <= {`EBRH_D_W{1'b0}};
      din_sync_reg   <= {`EBRH_D_W{1'b0}};
    end else begin
      ready_meta_reg <= ready_n;
      ready_sync_reg <= ready_meta_reg;
      hold_meta_reg  <= hold_request_n;
      hold_sync_reg  <= hold_meta_reg;
      din_meta_reg   <= bus_data_in;
      din_sync_reg   <= din_meta_reg;
    end
  end

  // register port: write, and read data one cycle later
  // only the low byte is mapped; unmapped offsets ignore writes and read as zero
  always @(posedge clk) begin
    if (srst) begin
      ctrl_reg  <= `EBRH_CTRL_RST;
      reg_rdata <= 32'h00000000;
    end else begin
      if (reg_wr && reg_addr == `EBRH_OFS_CTRL) begin
        ctrl_reg <= reg_wdata[`EBRH_CTRL_W-1:0];
      end
      if (reg_rd) begin
        case (reg_addr)
          `EBRH_OFS_CTRL:   reg_rdata <= {24'h000000, ctrl_reg};
          `EBRH_OFS_STATUS: reg_rdata <= {24'h000000, pend_reg, hold_req,
                                          ~bus_grant_ack_n, ~bus_regain_request_n,
                                          state_reg};
          default:          reg_rdata <= 32'h00000000;
        endcase
      end else begin
        reg_rdata <= 32'h00000000;
      end
    end
  end

  // start of a bus cycle from the pending request
  // multiplexed: the low 16 address bits ride the data lines while the latch is high
  task start_cycle;
    begin
      state_reg          <= `EBRH_ST_ALE;
      ale                <= 1'b1;
      bus_addr           <= pend_addr_reg;
      high_byte_select_n <= ~pend_be_reg[1];
      bus_data_out       <= mux_mode ? pend_addr_reg[`EBRH_D_W-1:0] : pend_wdata_reg;
      data_oe_n          <= ~(mux_mode | pend_write_reg);
    end
  endtask

  // idle decision: hold has priority over a new cycle
  // a waiting request cannot starve the master; it asks for the bus back instead
  task idle_decide;
    begin
      if (hold_req) begin
        state_reg       <= `EBRH_ST_GRANT;
        bus_grant_ack_n <= 1'b0;
        addr_oe_n       <= 1'b1;
        data_oe_n       <= 1'b1;
        ctrl_oe_n       <= 1'b1;
      end else if (pend_reg) begin
        start_cycle;
      end else begin
        state_reg <= `EBRH_ST_IDLE;
        data_oe_n <= 1'b1;
      end
    end
  endtask

  always @(posedge clk) begin
    if (srst) begin
      state_reg            <= `EBRH_ST_IDLE;
      wait_cnt_reg         <= `EBRH_MCW_ZERO;
      pend_reg             <= 1'b0;
      pend_write_reg       <= 1'b0;
      pend_be_reg          <= 2'h0;
      pend_addr_reg        <= {`EBRH_A_W{1'b0}};
      pend_wdata_reg       <= {`EBRH_D_W{1'b0}};
      req_busy             <= 1'b0;
      resp_done            <= 1'b0;
      resp_rdata           <= {`EBRH_D_W{1'b0}};
      ale                  <= 1'b0;
      rd_n                 <= 1'b1;
      wr_n                 <= 1'b1;
      high_byte_select_n   <= 1'b1;
      bus_addr             <= {`EBRH_A_W{1'b0}};
      bus_data_out         <= {`EBRH_D_W{1'b0}};
      addr_oe_n            <= 1'b0;
      data_oe_n            <= 1'b1;
      ctrl_oe_n            <= 1'b0;
      bus_grant_ack_n      <= 1'b1;
      bus_regain_request_n <= 1'b1;
    end else begin
      resp_done <= 1'b0;
      // request capture; busy refuses new requests until done
      // a request taken while granted waits here and raises the regain request
      if (req_valid && !pend_reg) begin
        pend_reg       <= 1'b1;
        pend_write_reg <= req_write;
        pend_be_reg    <= req_byte_en;
        pend_addr_reg  <= req_addr;
        pend_wdata_reg <= req_wdata;
        req_busy       <= 1'b1;
      end
      if (ce) begin
        case (state_reg)
          `EBRH_ST_IDLE: begin
            idle_decide;
          end
          `EBRH_ST_ALE: begin
            ale          <= 1'b0;
            bus_data_out <= pend_wdata_reg;
            data_oe_n    <= ~pend_write_reg;
            // memory waits count from the first command clock
            wait_cnt_reg <= mcw;
            if (rw_delay) begin
              state_reg <= `EBRH_ST_DLY;
            end else begin
              state_reg <= `EBRH_ST_CMD;
              rd_n      <= pend_write_reg;
              wr_n      <= ~pend_write_reg;
            end
          end
          `EBRH_ST_DLY: begin
            state_reg <= `EBRH_ST_CMD;
            rd_n      <= pend_write_reg;
            wr_n      <= ~pend_write_reg;
          end
          `EBRH_ST_CMD: begin
            // ready is looked at only once the memory waits have run out
            if (wait_cnt_reg != `EBRH_MCW_ZERO) begin
              wait_cnt_reg <= wait_cnt_reg - `EBRH_MCW_ONE;
            end else if (cmd_done) begin
              state_reg  <= `EBRH_ST_END;
              rd_n       <= 1'b1;
              wr_n       <= 1'b1;
              // data passes the same two flops as ready
              resp_rdata <= din_sync_reg;
              resp_done  <= 1'b1;
              pend_reg   <= 1'b0;
              req_busy   <= 1'b0;
            end else begin
              state_reg <= `EBRH_ST_CMD;
            end
          end
          `EBRH_ST_END: begin
            // ready may now be withdrawn by the responder
            if (mux_mode) begin
              state_reg <= `EBRH_ST_MUXW;
              data_oe_n <= 1'b1;
            end else if (tri_wait) begin
              state_reg <= `EBRH_ST_TRIW;
              data_oe_n <= 1'b1;
            end else begin
              idle_decide;
            end
          end
          `EBRH_ST_MUXW: begin
            // one idle output clock after a multiplexed cycle
            if (tri_wait) begin
              state_reg <= `EBRH_ST_TRIW;
            end else begin
              idle_decide;
            end
          end
          `EBRH_ST_TRIW: begin
            idle_decide;
          end
          `EBRH_ST_GRANT: begin
            // only hold going away hands the bus back; the regain request merely asks
            if (!hold_req) begin
              state_reg            <= `EBRH_ST_REGAIN;
              bus_grant_ack_n      <= 1'b1;
              bus_regain_request_n <= 1'b1;
            end else if (pend_reg) begin
              bus_regain_request_n <= 1'b0;
            end
          end
          `EBRH_ST_REGAIN: begin
            // one output clock of driven address and control before a new cycle
            addr_oe_n <= 1'b0;
            ctrl_oe_n <= 1'b0;
            state_reg <= `EBRH_ST_IDLE;
          end
          default: begin
            state_reg <= `EBRH_ST_IDLE;
          end
        endcase
      end
    end
  end

endmodule // ebrh_ctrl
`default_nettype wire

// ==== dv/ebrh_properties.sv ====
// assertions on the bus and arbitration pins of ebrh_ctrl
// assumes binding onto ebrh_ctrl, one clock domain, sync reset srst
`timescale 1ns/10ps
`default_nettype none
module ebrh_properties (
  // clock and reset
  input wire logic clk,
  input wire logic srst,
  // bus and arbitration pins, plus the resp_done strobe
  input wire logic system_clock_output,
  input wire logic ale,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic addr_oe_n,
  input wire logic data_oe_n,
  input wire logic ctrl_oe_n,
  input wire logic hold_request_n,
  input wire logic bus_grant_ack_n,
  input wire logic bus_regain_request_n,
  input wire logic resp_done
);
  wire idle = rd_n & wr_n;
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  a_grant_float: assert property (!bus_grant_ack_n |-> addr_oe_n && data_oe_n && ctrl_oe_n)
    else $error("bus driven while granted");
  a_grant_idle: assert property (!bus_grant_ack_n |-> idle && !ale)
    else $error("bus cycle while granted");
  a_regain_order: assert property (!bus_regain_request_n |-> !bus_grant_ack_n)
    else $error("regain request without grant");
  a_hold_release: assert property ($rose(bus_grant_ack_n) |-> $past(hold_request_n, 3))
    else $error("bus taken back while hold still requested");
  a_arb_edge: assert property ($changed({bus_grant_ack_n, bus_regain_request_n})
    |-> system_clock_output) else $error("arbitration output moved off clock output rise");
  a_clk_half: assert property (!$past(srst) |-> system_clock_output != $past(system_clock_output))
    else $error("clock output not clk over two");
  a_ale_width: assert property ($rose(ale) |=> ale ##1 !ale)
    else $error("address latch not one output clock");
  a_cmd_gap: assert property ($rose(idle) |-> !ale ##1 !ale)
    else $error("address latch too soon after command");
  a_done_end: assert property (resp_done |-> idle && !$past(idle))
    else $error("done without a command ending");
endmodule // ebrh_properties
bind ebrh_ctrl ebrh_properties chk_u (.clk, .srst, .system_clock_output, .ale, .rd_n, .wr_n,
  .addr_oe_n, .data_oe_n, .ctrl_oe_n, .hold_request_n, .bus_grant_ack_n,
  .bus_regain_request_n, .resp_done);
`default_nettype wire

// ==== dv/ebrh_partner.sv ====
// far side: slow-ready memory plus an external bus master
// assumes lclk unrelated to the controller clock; ready line pulled up
`timescale 1ns/10ps
`default_nettype none
module ebrh_partner (
  // link clock
  input  wire logic        lclk,
  // bus pins
  input  wire logic        rd_n,
  input  wire logic        wr_n,
  output wire logic        ready_n,
  output wire logic [15:0] bus_data_in,
  output var  logic        hold_request_n,
  // bench controls
  input  wire logic [3:0]  rdy_delay,
  input  wire logic [15:0] rd_word,
  input  wire logic        hold_want
);
  wire        idle = rd_n & wr_n;
  logic       rdy_q = 1'b1;
  logic [3:0] cnt = 4'h0;
  initial hold_request_n = 1'b1;
  // withdrawn at once on command end, so a following cycle never sees it early
  assign ready_n = rdy_q | idle;
  // released lines show the inverse, never a stale match
  assign bus_data_in = rd_n ? ~rd_word : rd_word;
  always @(posedge lclk or posedge idle) begin
    if (idle) begin
      rdy_q <= 1'b1;
      cnt <= 4'h0;
    end else if (cnt == rdy_delay) begin
      rdy_q <= 1'b0;
    end else begin
      cnt <= cnt + 4'h1;
    end
  end
  always @(posedge lclk) hold_request_n <= !hold_want;
endmodule // ebrh_partner
`default_nettype wire

// ==== dv/ebrh_ctrl_tb_top.sv ====
// self-checking bench of ebrh_ctrl: random configs, bursts, hold arbitration
// assumes ebrh_partner and the bound checker compiled before
`timescale 1ns/10ps
`default_nettype none
`include "ebrh_regs.vh"
module ebrh_ctrl_tb_top;
  logic        clk = 1'b0, srst = 1'b1, lclk = 1'b0, hold_want = 1'b0;
  logic        reg_wr = 1'b0, reg_rd = 1'b0, req_valid = 1'b0, req_write = 1'b0;
  logic [7:0]  reg_addr = 8'h00, cfg;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, seed = 32'h5E6CF989, rv;
  logic [1:0]  req_byte_en = 2'h3;
  logic [17:0] req_addr = 18'h0, bus_addr;
  logic [15:0] req_wdata = 16'h0, rd_word = 16'h0, resp_rdata, bus_data_out, bus_data_in;
  logic        req_busy, resp_done, system_clock_output, ale, rd_n, wr_n, high_byte_select_n;
  logic        addr_oe_n, data_oe_n, ctrl_oe_n, ready_n, hold_request_n;
  logic        bus_grant_ack_n, bus_regain_request_n;
  logic [3:0]  rdy_delay = 4'h0;
  int          err_total = 0, checks = 0, lo_c = 0, lo_last = 0, rdy_c = 0, rdy_last = 0;
  int          gap_c = 0, gap_last = 0, n_done = 0, p, k;
  always #10 clk = ~clk;
  initial begin
    #3;
    forever #80 lclk = ~lclk;
  end
  ebrh_ctrl dut_u (.clk, .srst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .req_valid, .req_write, .req_byte_en, .req_addr, .req_wdata, .req_busy, .resp_done,
    .resp_rdata, .system_clock_output, .ale, .rd_n, .wr_n, .high_byte_select_n, .bus_addr,
    .bus_data_out, .bus_data_in, .addr_oe_n, .data_oe_n, .ctrl_oe_n, .ready_n,
    .hold_request_n, .bus_grant_ack_n, .bus_regain_request_n);
  ebrh_partner far_u (.lclk, .rd_n, .wr_n, .ready_n, .bus_data_in, .hold_request_n,
    .rdy_delay, .rd_word, .hold_want);
  function automatic logic [31:0] xs(input logic [31:0] v);
    v = v ^ (v << 13);
    v = v ^ (v >> 17);
    return v ^ (v << 5);
  endfunction
  function automatic int exp_gap(input logic [7:0] c);
    return 2 + 2 * c[0] + 2 * c[3];
  endfunction
  function automatic int lo_min(input logic [7:0] c);
    return 2 * c[7:4] + 1;
  endfunction
  task automatic cmp_v(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp_in(input int got, input int lo, input int hi);
    checks++;
    if (got < lo || got > hi) begin
      err_total++;
      $display("[FAIL] %0t count %0d outside %0d..%0d", $time, got, lo, hi);
    end
  endtask
  task automatic reg_io(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= wr;
    reg_rd <= !wr;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    #1;
  endtask
  // 0 done, 1 granted, 2 released, 3 busy, 4 read strobe low
  task automatic wait_on(input int sel, input int lim);
    logic hit;
    hit = 1'b0;
    for (int i = 0; i < lim && !hit; i++) begin
      @(posedge clk);
      #1;
      hit = sel == 0 ? resp_done === 1'b1 : sel == 3 ? req_busy === 1'b1 :
            sel == 4 ? rd_n === 1'b0 : bus_grant_ack_n === (sel == 2);
    end
    if (!hit) begin
      err_total++;
      $display("[FAIL] %0t wait %0d timed out", $time, sel);
    end
  endtask
  task automatic start_req;
    @(posedge clk);
    req_valid <= 1'b1;
    req_write <= rv[0];
    req_addr <= rv[17:0];
    req_wdata <= rv[31:16];
    req_byte_en <= rv[3:2] | 2'h1;
    wait_on(3, 300);
    @(posedge clk);
    req_valid <= 1'b0;
  endtask
  task automatic tally_and_finish;
    $display("checks=%0d err_total=%0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  always @(negedge clk) begin
    if (ale === 1'b1) cmp_v({addr_oe_n, ctrl_oe_n, bus_addr}, {2'b00, req_addr});
    if (ale === 1'b1) cmp_v(high_byte_select_n, !req_byte_en[1]);
    if (wr_n === 1'b0) cmp_v({data_oe_n, bus_data_out}, {1'b0, req_wdata});
    if (resp_done === 1'b1) n_done++;
    if (rd_n === 1'b0 || wr_n === 1'b0) begin
      lo_c++;
      if (ready_n === 1'b0) rdy_c++;
    end else if (lo_c > 0) begin
      lo_last = lo_c;
      rdy_last = rdy_c;
      lo_c = 0;
      rdy_c = 0;
      gap_c = 1;
    end else if (gap_c > 0 && ale === 1'b1) begin
      gap_last = gap_c;
      gap_c = 0;
    end else if (gap_c > 0) gap_c++;
  end
  initial begin
    #600000;
    err_total++;
    $display("[FAIL] %0t watchdog expired", $time);
    tally_and_finish;
  end
  initial begin
    repeat (10) @(posedge clk);
    srst <= 1'b0;
    reg_io(1'b0, `EBRH_OFS_CTRL, 32'h0);
    cmp_v(reg_rdata, {24'h0, `EBRH_CTRL_RST});
    reg_io(1'b1, 8'h08, 32'hFF);
    reg_io(1'b0, 8'h08, 32'h0);
    cmp_v(reg_rdata, 32'h0);
    for (p = 0; p < 8; p++) begin
      rv = xs(seed);
      seed = rv;
      cfg = p < 2 ? (p ? 8'h3F : 8'h00) : {2'b00, rv[5:4], rv[3] & rv[0], rv[2:0]};
      rdy_delay <= {2'b00, rv[9:8]};
      rd_word <= rv[31:16];
      reg_io(1'b1, `EBRH_OFS_CTRL, {24'h0, cfg});
      reg_io(1'b0, `EBRH_OFS_CTRL, 32'h0);
      cmp_v(reg_rdata, {24'h0, cfg});
      rv[0] = 1'b0;
      start_req;
      wait_on(0, 400);
      // the monitor books the command width on the falling edge after the end
      @(negedge clk);
      #1;
      // the data flops need more than two clk of command to see the driven word
      if (lo_last > 2) cmp_v(resp_rdata, rd_word);
      cmp_in(lo_last, lo_min(cfg), cfg[2] ? 999 : lo_min(cfg) + 1);
      if (cfg[2]) cmp_in(lo_last, 8 * rdy_delay, 999);
      if (cfg[2]) cmp_in(rdy_last, 0, 2 * cfg[7:4] + 6);
      @(posedge clk);
      req_valid <= 1'b1;
      req_write <= rv[1];
      repeat (3) wait_on(0, 400);
      @(posedge clk);
      req_valid <= 1'b0;
      wait_on(0, 400);
      cmp_in(gap_last, exp_gap(cfg), exp_gap(cfg));
    end
    for (p = 0; p < 2; p++) begin
      reg_io(1'b1, `EBRH_OFS_CTRL, 32'h04);
      rdy_delay <= 4'h3;
      k = n_done;
      if (p) start_req;
      if (p) wait_on(4, 100);
      @(posedge clk);
      hold_want <= 1'b1;
      wait_on(1, 400);
      cmp_v(n_done - k, p);
      if (p) start_req;
      repeat (30) @(posedge clk);
      #1;
      cmp_v(bus_regain_request_n, !p);
      cmp_v(bus_grant_ack_n, 1'b0);
      reg_io(1'b0, `EBRH_OFS_STATUS, 32'h0);
      cmp_v(reg_rdata, {24'h0, p[0], 2'b11, p[0], `EBRH_ST_GRANT});
      @(posedge clk);
      hold_want <= 1'b0;
      wait_on(2, 100);
      if (p) wait_on(0, 400);
    end
    tally_and_finish;
  end
endmodule // ebrh_ctrl_tb_top
`default_nettype wire
